// ---- adc_seq_map.svh ----
// Named constants for the converter sequencer: word fields, codes and timing.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define CFG_WRITE 15
`define CFG_REPEAT 14
`define CFG_CH0 13
`define CFG_TEMP 4
`define CFG_EXTREF 2
`define CFG_AVG 1
`define CFG_PPD 0
`define CFG_RESET 15'h0000
`define TEMP_INDEX 8
`define TAG_TEMP 4'h8
`define TAG_TEMP_AVG 4'h9
`define WORD_ONES 16'hffff
`define FRAME_BITS 5'h10
`define TRACK_EDGE 5'h0e
`define CLK_PERIOD_NS 8
`define RST_LOW_NS 100
`define RST_LOW_CYC ((`RST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- adc_seq_pkg.sv ----
// State types for the converter sequencer.
package adc_seq_pkg;
   // Link side frame state, cleared whenever chip-select is high.
   typedef struct packed {
      logic [4:0] cnt;
      logic [15:0] shift;
      logic [15:0] word;
      logic cmp;
      logic trk;
      logic dout;
      logic oe;
   } link_t;
   // System side sequencer state.
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_d;
      logic cmp_s1;
      logic cmp_s2;
      logic trk_s1;
      logic trk_s2;
      logic rst_s1;
      logic rst_s2;
      logic [3:0] rst_cnt;
      logic full_sleep;
      logic [14:0] cfg;
      logic [8:0] pending;
      logic sleep;
      logic waking;
      logic conv_valid;
      logic [3:0] conv_ch;
      logic conv_start;
      logic got;
      logic wrote;
      logic hold;
      logic [11:0] avg;
      logic avg_ok;
      logic [15:0] out_word;
   } core_t;
endpackage

// ---- adc_sequencer.sv ----
// Serial frame engine, channel sequencer and power modes of the converter.
//
// Contract
// - Result appears in frame after its conversion.
// - First configuring frame returns invalid data.
// - Single pass converts selected channels ascending once.
// - Finished or empty sequence returns all ones.
// - Repeat cycles ascending and wraps to lowest.
// - Any write in repeat restarts the sequence.
// - Temperature converts after last analog channel.
// - Chip-select fall holds; edge fourteen tracks.
// - Word loads only when write bit set.
// - Stays powered while partial sleep bit zero.
// - Partial sleep starts at frame end rise.
// - Partial sleep returns all ones.
// - Entering sleep clears temperature average.
// - Wake needs full config write before converting.
// - First valid result in fourth frame after.
// - Long low pin gives full power-down.
// - Short low pin resets all registers.
// - Power-on clears configuration to zeros.
// - Configuration word field positions.
// - Result carries four bit channel tag.
// - Early chip-select rise abandons the frame.
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module adc_sequencer (
   // System clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Serial link from the host.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // Reset or power-down pin.
   input wire logic reset_or_sleep_pin,
   // Converter core.
   input wire logic [11:0] conv_result,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic track_hold,
   // Power and reference status.
   output logic partial_sleep,
   output logic full_sleep,
   output logic outside_reference_select
);

   adc_seq_pkg::link_t l;
   adc_seq_pkg::link_t next_l;
   adc_seq_pkg::core_t c;
   adc_seq_pkg::core_t next_c;
   logic [8:0] sel;
   logic fall;
   logic rise;
   logic take;

   // Lowest set position of a channel mask; temperature is last.
   function automatic logic [3:0] first_set(input logic [8:0] m);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 8; i >= 0; i--)
      begin
         if (m[i])
         begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Defaults after reset or a reset pulse on the pin.
   function automatic adc_seq_pkg::core_t core_reset();
      adc_seq_pkg::core_t r;
      r = '0;
      r.cs_s1 = 1'b1;
      r.cs_s2 = 1'b1;
      r.cs_d = 1'b1;
      r.rst_s1 = 1'b1;
      r.rst_s2 = 1'b1;
      r.cfg = `CFG_RESET;
      r.out_word = `WORD_ONES;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: one frame of sixteen serial clocks.

   // Shift in the control word and shift out the result word.
   always_comb
   begin
      next_l = l;
      if (l.cnt != `FRAME_BITS)
      begin
         next_l.cnt = l.cnt + 5'h01;
         next_l.shift = {l.shift[14:0], din};
         next_l.oe = 1'b1;
         next_l.dout = c.out_word[4'(`FRAME_BITS - 5'h01 - l.cnt)];
         if (l.cnt == `TRACK_EDGE - 5'h01)
         begin
            next_l.trk = 1'b1;
         end
         if (l.cnt == `FRAME_BITS - 5'h01)
         begin
            next_l.word = {l.shift[14:0], din};
            next_l.cmp = 1'b1;
         end
      end
      else
      begin
         next_l.oe = 1'b0;
      end
   end

   // The frame's own chip-select ends it, so an idle serial clock is harmless.
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
      begin
         l <= '0;
      end
      else
      begin
         l <= next_l;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // System domain: sequencer and power control.

   // Frame edges and the channels named by the configuration.
   always_comb
   begin
      fall = c.cs_d & ~c.cs_s2;
      rise = ~c.cs_d & c.cs_s2;
      take = c.cmp_s2 & ~c.got & ~c.cs_s2;
      for (int i = 0; i < 8; i++)
      begin
         sel[i] = c.cfg[`CFG_CH0 - i];
      end
      sel[`TEMP_INDEX] = c.cfg[`CFG_TEMP];
   end

   // Next state of the sequencer.
   always_comb
   begin
      logic [8:0] rest;
      logic [15:0] res;
      rest = 9'h000;
      res = `WORD_ONES;
      next_c = c;
      next_c.cs_s1 = cs_n;
      next_c.cs_s2 = c.cs_s1;
      next_c.cs_d = c.cs_s2;
      next_c.cmp_s1 = l.cmp;
      next_c.cmp_s2 = c.cmp_s1;
      next_c.trk_s1 = l.trk;
      next_c.trk_s2 = c.trk_s1;
      next_c.rst_s1 = reset_or_sleep_pin;
      next_c.rst_s2 = c.rst_s1;
      next_c.conv_start = 1'b0;
      if (!c.rst_s2)
      begin
         // Low pin: everything returns to defaults; long low is full power-down.
         next_c = core_reset();
         next_c.cs_s1 = cs_n;
         next_c.cs_s2 = c.cs_s1;
         next_c.cs_d = c.cs_s2;
         next_c.rst_s1 = reset_or_sleep_pin;
         next_c.rst_s2 = c.rst_s1;
         next_c.rst_cnt = (c.rst_cnt == 4'hf) ? c.rst_cnt : c.rst_cnt + 4'h1;
         next_c.full_sleep = (c.rst_cnt >= 4'(`RST_LOW_CYC));
      end
      else
      begin
         next_c.rst_cnt = 4'h0;
         next_c.full_sleep = 1'b0;
         if (c.trk_s2)
         begin
            next_c.hold = 1'b0;
         end
         if (fall)
         begin
            // Start the next conversion unless asleep or waking.
            next_c.got = 1'b0;
            next_c.wrote = 1'b0;
            next_c.conv_valid = (|c.pending) & ~c.sleep & ~c.waking;
            next_c.conv_ch = first_set(c.pending);
            next_c.conv_start = next_c.conv_valid;
            next_c.hold = 1'b1;
         end
         if (take)
         begin
            next_c.got = 1'b1;
            next_c.wrote = l.word[`CFG_WRITE];
            if (l.word[`CFG_WRITE])
            begin
               next_c.cfg = l.word[14:0];
            end
         end
         if (rise)
         begin
            next_c.hold = 1'b0;
            next_c.got = 1'b0;
            next_c.wrote = 1'b0;
            if (c.got)
            begin
               // Complete frame: publish result, advance sequence, apply sleep.
               if (c.conv_valid)
               begin
                  res = {c.conv_ch, conv_result};
                  if (c.conv_ch == 4'(`TEMP_INDEX) && c.cfg[`CFG_AVG])
                  begin
                     next_c.avg = c.avg_ok ?
                        12'((13'(c.avg) + 13'(conv_result)) >> 1) : conv_result;
                     next_c.avg_ok = 1'b1;
                     res = {`TAG_TEMP_AVG, next_c.avg};
                  end
                  else if (c.conv_ch == 4'(`TEMP_INDEX))
                  begin
                     res = {`TAG_TEMP, conv_result};
                  end
               end
               next_c.out_word = res;
               rest = c.pending;
               if (c.conv_valid)
               begin
                  rest[c.conv_ch] = 1'b0;
               end
               if (c.wrote)
               begin
                  next_c.pending = sel;
               end
               else if (rest == 9'h000 && c.cfg[`CFG_REPEAT])
               begin
                  next_c.pending = sel;
               end
               else
               begin
                  next_c.pending = rest;
               end
               if (c.wrote)
               begin
                  next_c.sleep = c.cfg[`CFG_PPD];
                  next_c.waking = c.sleep & ~c.cfg[`CFG_PPD];
               end
               if (next_c.sleep)
               begin
                  next_c.out_word = `WORD_ONES;
               end
               if (next_c.sleep & ~c.sleep)
               begin
                  next_c.avg_ok = 1'b0;
                  next_c.avg = 12'h000;
               end
            end
         end
      end
   end

   // Register the sequencer state; defaults hold a zero configuration.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         c <= core_reset();
      end
      else
      begin
         c <= next_c;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flip-flop.

   assign dout = l.dout;
   assign dout_oe = l.oe;
   assign conv_start = c.conv_start;
   assign conv_channel = c.conv_ch;
   assign track_hold = c.hold;
   assign partial_sleep = c.sleep;
   assign full_sleep = c.full_sleep;
   assign outside_reference_select = c.cfg[`CFG_EXTREF];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the system side.

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_hold;
      fall && c.rst_s2 |=> c.hold;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not set at frame start");

   property p_no_write;
      take && !l.word[`CFG_WRITE] && c.rst_s2 |=> $stable(c.cfg);
   endproperty
   a_no_write: assert property (p_no_write) else $error("config changed without write");

   property p_abort;
      rise && !c.got && c.rst_s2 |=> $stable(c.out_word) && $stable(c.pending);
   endproperty
   a_abort: assert property (p_abort) else $error("aborted frame changed state");

   property p_tag;
      rise && c.got && c.conv_valid && c.conv_ch < 4'h8 && !c.wrote && !c.sleep && c.rst_s2
         |=> c.out_word[15:12] == $past(c.conv_ch);
   endproperty
   a_tag: assert property (p_tag) else $error("result tag mismatch");

   property p_empty;
      rise && c.got && !c.conv_valid && c.rst_s2 |=> c.out_word == `WORD_ONES;
   endproperty
   a_empty: assert property (p_empty) else $error("empty frame not all ones");

   property p_restart;
      rise && c.got && c.wrote && c.rst_s2 |=> c.pending == $past(sel);
   endproperty
   a_restart: assert property (p_restart) else $error("write did not restart sequence");

   property p_sleep_ones;
      $rose(c.sleep) |-> c.out_word == `WORD_ONES ##1 (c.out_word == `WORD_ONES)[*2];
   endproperty
   a_sleep_ones: assert property (p_sleep_ones) else $error("sleep output not ones");

   property p_wake;
      fall && c.waking && c.rst_s2 |=> !c.conv_start;
   endproperty
   a_wake: assert property (p_wake) else $error("conversion while waking");

   property p_full;
      !c.rst_s2 && c.rst_cnt >= 4'(`RST_LOW_CYC) |=> c.full_sleep && c.cfg == `CFG_RESET;
   endproperty
   a_full: assert property (p_full) else $error("long pin low not power-down");

   property p_wrap;
      rise && c.got && c.conv_valid && !c.wrote && c.cfg[`CFG_REPEAT] && c.rst_s2
         && c.pending == (9'h001 << c.conv_ch) |=> c.pending == $past(sel);
   endproperty
   a_wrap: assert property (p_wrap) else $error("repeat did not wrap");

endmodule

// ---- host_link.sv ----
// Host serial master model that frames words to the converter sequencer.
`timescale 1ns/1ps

module host_link (
   // Serial link to the device.
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   ////////////////////////////////////////////////////////////////////////
   // The link clock stands still and chip-select is high between frames.
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // Sends n clocks of word w at a 6 ns period and returns what was read.
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'hffff;
      cs_n = 1'b0;
      #30;
      for (int k = 1; k <= n; k++)
      begin
         din = w[16 - k];
         #3 sclk = 1'b1;
         #3 sclk = 1'b0;
         r[16 - k] = dout;
      end
      // Chip-select stays low a few system clocks after the last edge so the
      // captured word is taken before chip-select high clears the frame.
      #30 cs_n = 1'b1;
      // The quiet gap also covers the resynchronisation of chip-select.
      #100;
   endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps

module tb_top;
   // Clock, reset and device pins.
   logic clk;
   logic reset_n;
   logic reset_or_sleep_pin;
   logic [11:0] conv_result;
   logic sclk, cs_n, din, dout;
   logic [3:0] conv_channel;
   logic partial_sleep, full_sleep, outside_reference_select;
   logic [15:0] rd;
   logic dout_oe, conv_start, track_hold;
   int conv_count;
   int oe_count;
   int fail_count;
   int check_count;

   ////////////////////////////////////////////////////////////////////////
   // Design, host model and converter data that marks its channel.
   adc_sequencer dut_u (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .din(din), .dout(dout), .dout_oe(dout_oe), .reset_or_sleep_pin(reset_or_sleep_pin),
      .conv_result(conv_result), .conv_start(conv_start), .conv_channel(conv_channel),
      .track_hold(track_hold), .partial_sleep(partial_sleep), .full_sleep(full_sleep),
      .outside_reference_select(outside_reference_select));
   host_link host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   always @(posedge clk)
      conv_result <= 12'h5a0 | {8'h00, conv_channel};

   // Count conversion starts and frames in which the output was driven.
   always @(posedge clk)
      if (conv_start === 1'b1)
         conv_count++;
   always @(posedge dout_oe)
      oe_count++;

   // System clock at 125 MHz.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare tasks, frame task and the closing report.
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic xfer(input logic [15:0] w, input logic [15:0] exp, input logic en);
      host_u.frame(w, 16, rd);
      if (en)
         chk16(rd, exp);
   endtask

   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard.
   initial
   begin
      #300000;
      fail_count++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      reset_n = 1'b0;
      reset_or_sleep_pin = 1'b1;
      conv_result = 12'h000;
      fail_count = 0;
      check_count = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk1(outside_reference_select, 1'b0);
      // Single pass over inputs 0 and 1, then all ones.
      xfer(16'hb000, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h05a0, 1'b1);
      xfer(16'h0000, 16'h15a1, 1'b1);
      xfer(16'h0000, 16'hffff, 1'b1);
      chk1(partial_sleep, 1'b0);
      // Repeat over inputs 6, 7 and temperature, with a restarting rewrite.
      xfer(16'hc0d0, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h65a6, 1'b1);
      xfer(16'h0000, 16'h75a7, 1'b1);
      xfer(16'h0000, 16'h85a8, 1'b1);
      xfer(16'hc0d0, 16'h65a6, 1'b1);
      xfer(16'h0000, 16'h75a7, 1'b1);
      xfer(16'h0000, 16'h65a6, 1'b1);
      // Leave repeat with nothing selected.
      xfer(16'h8000, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h0000, 1'b0);
      xfer(16'h0000, 16'hffff, 1'b1);
      // A cut-short write must not reach the configuration.
      host_u.frame(16'h8001, 8, rd);
      chk1(partial_sleep, 1'b0);
      // Partial sleep, then wake and a fresh conversion of input 3.
      xfer(16'h8001, 16'h0000, 1'b0);
      chk1(partial_sleep, 1'b1);
      xfer(16'h0000, 16'hffff, 1'b1);
      xfer(16'h8000, 16'h0000, 1'b0);
      xfer(16'h8400, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h0000, 1'b0);
      xfer(16'h0000, 16'h35a3, 1'b1);
      // Short pin pulse resets; a long one powers down.
      xfer(16'h8004, 16'h0000, 1'b0);
      chk1(outside_reference_select, 1'b1);
      @(posedge clk) reset_or_sleep_pin <= 1'b0;
      repeat (4) @(posedge clk);
      reset_or_sleep_pin <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk1(outside_reference_select, 1'b0);
      chk1(full_sleep, 1'b0);
      @(posedge clk) reset_or_sleep_pin <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk1(full_sleep, 1'b1);
      @(posedge clk) reset_or_sleep_pin <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      // Eleven valid conversions and twenty-four driven frames were sent.
      chk16(16'(conv_count), 16'h000b);
      chk16(16'(oe_count), 16'h0018);
      chk1(track_hold, 1'b0);
      chk1(dout_oe, 1'b0);
      end_of_test();
   end
endmodule
